//--- inc/stx_pkg.sv
package stx_pkg;

   // ***************************************************
   // Register map, word aligned byte offsets
   // ***************************************************
   localparam int STX_AW = 8;
   localparam logic [7:0] OFS_ST0 = 8'h00;
   localparam logic [7:0] OFS_ST1 = 8'h04;
   localparam logic [7:0] OFS_ST2 = 8'h08;
   localparam logic [7:0] OFS_DSP = 8'h0c;
   localparam logic [7:0] OFS_SSP = 8'h10;
   localparam logic [7:0] OFS_VECTOR_PTR_DSP = 8'h14;
   localparam logic [7:0] OFS_VECTOR_PTR_HOST = 8'h18;
   localparam logic [7:0] OFS_DBST = 8'h1c;
   localparam logic [7:0] OFS_RETPAIR = 8'h20;
   localparam logic [7:0] OFS_CTRL = 8'h24;
   localparam logic [7:0] OFS_STAT = 8'h28;

   // ***************************************************
   // Status word reset values and fields
   // ***************************************************
   localparam logic [15:0] ST0_RST = 16'h3800;
   localparam logic [15:0] ST1_RST = 16'h2920;
   localparam logic [15:0] ST2_RST = 16'h1000;
   localparam logic [15:0] ST2_WMASK = 16'h9dff;
   localparam int ST0_HI_LSB = 9;
   localparam int ST1_GIM_BIT = 11;
   localparam int ST2_AUX_REG_MODE_SELECT_BIT = 15;
   localparam int ST2_DEBUG_EVENT_DISABLE_BIT = 12;
   localparam int ST2_EMULATION_WRITE_PERMIT_BIT = 11;
   localparam int ST2_RDM_BIT = 10;
   localparam int CTRL_FAST_BIT = 0;
   localparam int CTRL_FLOW_LSB = 8;
   localparam logic [15:0] RST_PTR = 16'h0000;

   // ***************************************************
   // Trap opcode and vector layout
   // ***************************************************
   localparam logic [15:0] OPC_TRAP_MASK = 16'hff80;
   localparam logic [15:0] OPC_TRAP_VAL = 16'h9580;
   localparam int VEC_IDX_W = 5;
   localparam logic [4:0] HOST_VEC_LO = 5'h10;
   localparam logic [4:0] HOST_VEC_HI = 5'h17;

   typedef enum logic [2:0] {
      STX_IDLE, STX_PH_ADDR, STX_PH_ACC, STX_PH_READ, STX_VEC_REQ, STX_VEC_WAIT
   } stx_phase_e;

   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [15:0] data;
   } stx_push_s;

   function automatic logic [23:0] stx_vec_addr(input logic [15:0] ivp,
                                                input logic [4:0] idx);
      return {ivp, idx, 3'b000};
   endfunction

   function automatic logic [15:0] stx_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0] sel);
      return {sel[1] ? new_v[15:8] : old_v[15:8],
              sel[0] ? new_v[7:0] : old_v[7:0]};
   endfunction

endpackage

//--- design/stx_status_bank.sv
`timescale 1ns/100ps
`default_nettype none
module stx_status_bank (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic soft_rst,
   input wire logic [2:0] wr_en,
   input wire logic [1:0] wr_sel,
   input wire logic [15:0] wr_data,
   output logic [15:0] st0,
   output logic [15:0] st1,
   output logic [15:0] st2
);
   import stx_pkg::*;

   typedef struct packed {
      logic [15:0] st0;
      logic [15:0] st1;
      logic [15:0] st2;
   } stx_bank_s;

   stx_bank_s s_r;
   stx_bank_s s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (soft_rst)
      begin
         s_nxt.st0 = ST0_RST;
         s_nxt.st1 = ST1_RST;
         s_nxt.st2 = ST2_RST;
      end
      else
      begin
         if (wr_en[0])
            s_nxt.st0 = stx_merge(s_r.st0, wr_data, wr_sel);
         if (wr_en[1])
            s_nxt.st1 = stx_merge(s_r.st1, wr_data, wr_sel);
         if (wr_en[2])
            s_nxt.st2 = stx_merge(s_r.st2, wr_data, wr_sel) & ST2_WMASK;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
         s_r <= '{ST0_RST, ST1_RST, ST2_RST};
      else
         s_r <= s_nxt;
   end

   assign st0 = s_r.st0;
   assign st1 = s_r.st1;
   assign st2 = s_r.st2;

   a_st2_reserved_zero: assert property (@(posedge core_clk) disable iff (srst)
      (st2 & ~ST2_WMASK) == 16'h0000)
      else $error("Reserved status bits not zero");

endmodule // stx_status_bank
`default_nettype wire

//--- design/stx_trap_unit.sv
// Contract
// - Trap vector address is the selected vector pointer joined with 5-bit index and three zero bits.
// - Trap runs unmasked and leaves global mask and debug disable unchanged.
// - Address phase: push status two on data stack, status zero high bits.
// - Access phase: push status one on data stack, debug status on system.
// - Read phase: push return address low, loop bits with address high.
// - After pushes, load program counter with routine address, clear flow flags.
// - Slow return by default stores return context in stack memory.
// - Fast return keeps address and loop bits in a 32-bit register pair.
// - A trap under a repeat construct is refused.
// - Soft reset clears aux mode select and sets debug disable.
// - Soft reset clears the emulation write permit, blocking emulation writes.
// - Soft reset clears rounding mode select, giving round toward infinity.
// - Soft reset clears all circular select bits, giving linear addressing.
// - Soft reset clears overflow flags and data page, sets test flags, carry.
// - Soft reset keeps vector pointers, sets global mask, clears pending flags.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module stx_trap_unit #(
   parameter int VEC_W = 5
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [stx_pkg::STX_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic trap_req,
   input wire logic [15:0] trap_opcode,
   input wire logic [23:0] trap_ret_pc,
   input wire logic repeat_active,
   output logic trap_busy,
   output logic trap_reject,
   output logic vec_rd,
   output logic [23:0] vec_addr,
   input wire logic vec_ack,
   input wire logic [23:0] vec_data,
   output logic pc_load,
   output logic [23:0] pc_value,
   input wire logic soft_rst_req,
   output logic irq_flags_clr,
   output stx_pkg::stx_push_s data_push,
   output stx_pkg::stx_push_s sys_push,
   output logic [15:0] st0,
   output logic [15:0] st1,
   output logic [15:0] st2,
   output logic debug_event_disable,
   output logic emulation_write_permit,
   output logic rounding_mode_select
);
   import stx_pkg::*;

   if (VEC_W != VEC_IDX_W)
      $error("stx_trap_unit: vector index width must be 5");

   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      stx_phase_e ph;
      logic [15:0] sp;
      logic [15:0] system_stack_pointer;
      logic [15:0] vector_ptr_dsp;
      logic [15:0] vector_ptr_host;
      logic [15:0] debug_context_status;
      logic [23:0] return_addr_reg;
      logic [7:0] flow_context_reg;
      logic [7:0] flow_ctx;
      logic fast;
      logic [4:0] idx;
      logic [23:0] ret_pc;
      logic [23:0] isr_pc;
      logic ack;
      logic [31:0] dat;
      stx_push_s dpush;
      stx_push_s spush;
      logic vec_rd;
      logic [23:0] vaddr;
      logic pc_load;
      logic reject;
      logic last_reject;
      logic irq_clr;
   } stx_state_s;

   stx_state_s s_r;
   stx_state_s s_nxt;
   logic [2:0] st_we;
   logic bus_hit;
   logic bus_wr;
   logic is_trap;
   logic [15:0] wlo;

   stx_status_bank u_bank (
      .core_clk(core_clk),
      .srst(srst),
      .soft_rst(soft_rst_req),
      .wr_en(st_we),
      .wr_sel(wb_sel_i[1:0]),
      .wr_data(wb_dat_i[15:0]),
      .st0(st0),
      .st1(st1),
      .st2(st2)
   );

   function automatic logic [15:0] pick_ivp(input logic [4:0] idx,
                                            input logic [15:0] vector_ptr_dsp,
                                            input logic [15:0] vector_ptr_host);
      return (idx >= HOST_VEC_LO && idx <= HOST_VEC_HI) ? vector_ptr_host : vector_ptr_dsp;
   endfunction

   // ***************************************************
   // Bus decode and sequencer
   // ***************************************************
   always_comb
   begin
      s_nxt = s_r;
      bus_hit = wb_cyc_i && wb_stb_i;
      bus_wr = bus_hit && wb_we_i && s_r.ack;
      wlo = wb_dat_i[15:0];
      st_we = 3'b000;
      is_trap = (trap_opcode & OPC_TRAP_MASK) == OPC_TRAP_VAL;
      s_nxt.ack = bus_hit && !s_r.ack;
      s_nxt.dpush.we = 1'b0;
      s_nxt.spush.we = 1'b0;
      s_nxt.pc_load = 1'b0;
      s_nxt.reject = 1'b0;
      s_nxt.irq_clr = soft_rst_req;
      if (bus_hit && !s_r.ack)
      begin
         if (wb_adr_i == OFS_ST0)
            s_nxt.dat = {16'h0000, st0};
         else if (wb_adr_i == OFS_ST1)
            s_nxt.dat = {16'h0000, st1};
         else if (wb_adr_i == OFS_ST2)
            s_nxt.dat = {16'h0000, st2};
         else if (wb_adr_i == OFS_DSP)
            s_nxt.dat = {16'h0000, s_r.sp};
         else if (wb_adr_i == OFS_SSP)
            s_nxt.dat = {16'h0000, s_r.system_stack_pointer};
         else if (wb_adr_i == OFS_VECTOR_PTR_DSP)
            s_nxt.dat = {16'h0000, s_r.vector_ptr_dsp};
         else if (wb_adr_i == OFS_VECTOR_PTR_HOST)
            s_nxt.dat = {16'h0000, s_r.vector_ptr_host};
         else if (wb_adr_i == OFS_DBST)
            s_nxt.dat = {16'h0000, s_r.debug_context_status};
         else if (wb_adr_i == OFS_RETPAIR)
            s_nxt.dat = {s_r.flow_context_reg, s_r.return_addr_reg};
         else if (wb_adr_i == OFS_CTRL)
            s_nxt.dat = {16'h0000, s_r.flow_ctx, 7'h00, s_r.fast};
         else if (wb_adr_i == OFS_STAT)
            s_nxt.dat = {29'h0, s_r.last_reject, s_r.vec_rd,
                         s_r.ph != STX_IDLE};
         else
            s_nxt.dat = 32'h0000_0000;
      end
      if (bus_wr)
      begin
         if (wb_adr_i == OFS_ST0)
            st_we = 3'b001;
         else if (wb_adr_i == OFS_ST1)
            st_we = 3'b010;
         else if (wb_adr_i == OFS_ST2)
            st_we = 3'b100;
         else if (wb_adr_i == OFS_DSP)
            s_nxt.sp = stx_merge(s_r.sp, wlo, wb_sel_i[1:0]);
         else if (wb_adr_i == OFS_SSP)
            s_nxt.system_stack_pointer = stx_merge(s_r.system_stack_pointer, wlo, wb_sel_i[1:0]);
         else if (wb_adr_i == OFS_VECTOR_PTR_DSP)
            s_nxt.vector_ptr_dsp = stx_merge(s_r.vector_ptr_dsp, wlo, wb_sel_i[1:0]);
         else if (wb_adr_i == OFS_VECTOR_PTR_HOST)
            s_nxt.vector_ptr_host = stx_merge(s_r.vector_ptr_host, wlo, wb_sel_i[1:0]);
         else if (wb_adr_i == OFS_DBST)
            s_nxt.debug_context_status = stx_merge(s_r.debug_context_status, wlo, wb_sel_i[1:0]);
         else if (wb_adr_i == OFS_RETPAIR)
         begin
            s_nxt.return_addr_reg[15:0] = stx_merge(s_r.return_addr_reg[15:0], wlo,
                                         wb_sel_i[1:0]);
            if (wb_sel_i[2])
               s_nxt.return_addr_reg[23:16] = wb_dat_i[23:16];
            if (wb_sel_i[3])
               s_nxt.flow_context_reg = wb_dat_i[31:24];
         end
         else if (wb_adr_i == OFS_CTRL)
         begin
            if (wb_sel_i[0])
               s_nxt.fast = wb_dat_i[CTRL_FAST_BIT];
            if (wb_sel_i[1])
               s_nxt.flow_ctx = wb_dat_i[CTRL_FLOW_LSB +: 8];
         end
      end
      case (s_r.ph)
         STX_IDLE:
         begin
            if (trap_req)
            begin
               if (repeat_active || !is_trap)
               begin
                  s_nxt.reject = 1'b1;
                  s_nxt.last_reject = 1'b1;
               end
               else
               begin
                  // Accepted regardless of the global mask
                  s_nxt.ph = STX_PH_ADDR;
                  s_nxt.idx = trap_opcode[4:0];
                  s_nxt.ret_pc = trap_ret_pc;
                  s_nxt.last_reject = 1'b0;
               end
            end
         end
         STX_PH_ADDR:
         begin
            s_nxt.sp = s_r.sp - 16'h0001;
            s_nxt.dpush = '{1'b1, s_r.sp - 16'h0001, st2};
            s_nxt.system_stack_pointer = s_r.system_stack_pointer - 16'h0001;
            s_nxt.spush = '{1'b1, s_r.system_stack_pointer - 16'h0001,
                            {st0[15:ST0_HI_LSB], 9'h000}};
            s_nxt.ph = STX_PH_ACC;
         end
         STX_PH_ACC:
         begin
            s_nxt.sp = s_r.sp - 16'h0001;
            s_nxt.dpush = '{1'b1, s_r.sp - 16'h0001, st1};
            s_nxt.system_stack_pointer = s_r.system_stack_pointer - 16'h0001;
            s_nxt.spush = '{1'b1, s_r.system_stack_pointer - 16'h0001, s_r.debug_context_status};
            s_nxt.ph = STX_PH_READ;
         end
         STX_PH_READ:
         begin
            if (s_r.fast)
            begin
               s_nxt.return_addr_reg = s_r.ret_pc;
               s_nxt.flow_context_reg = s_r.flow_ctx;
            end
            else
            begin
               s_nxt.sp = s_r.sp - 16'h0001;
               s_nxt.dpush = '{1'b1, s_r.sp - 16'h0001, s_r.ret_pc[15:0]};
               s_nxt.system_stack_pointer = s_r.system_stack_pointer - 16'h0001;
               s_nxt.spush = '{1'b1, s_r.system_stack_pointer - 16'h0001,
                               {s_r.flow_ctx, s_r.ret_pc[23:16]}};
            end
            s_nxt.ph = STX_VEC_REQ;
         end
         STX_VEC_REQ:
         begin
            s_nxt.vec_rd = 1'b1;
            s_nxt.vaddr = stx_vec_addr(pick_ivp(s_r.idx, s_r.vector_ptr_dsp, s_r.vector_ptr_host),
                                       s_r.idx);
            s_nxt.ph = STX_VEC_WAIT;
         end
         STX_VEC_WAIT:
         begin
            if (vec_ack)
            begin
               s_nxt.vec_rd = 1'b0;
               s_nxt.isr_pc = vec_data;
               s_nxt.pc_load = 1'b1;
               s_nxt.flow_ctx = 8'h00;
               s_nxt.ph = STX_IDLE;
            end
         end
         default:
            s_nxt.ph = STX_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         s_r <= '0;
         s_r.ph <= STX_IDLE;
         s_r.sp <= RST_PTR;
         s_r.system_stack_pointer <= RST_PTR;
      end
      else
         s_r <= s_nxt;
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.dat;
   assign trap_busy = s_r.ph != STX_IDLE;
   assign trap_reject = s_r.reject;
   assign vec_rd = s_r.vec_rd;
   assign vec_addr = s_r.vaddr;
   assign pc_load = s_r.pc_load;
   assign pc_value = s_r.isr_pc;
   assign irq_flags_clr = s_r.irq_clr;
   assign data_push = s_r.dpush;
   assign sys_push = s_r.spush;
   assign debug_event_disable = st2[ST2_DEBUG_EVENT_DISABLE_BIT];
   assign emulation_write_permit = st2[ST2_EMULATION_WRITE_PERMIT_BIT];
   assign rounding_mode_select = st2[ST2_RDM_BIT];

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_three_phase;
      s_r.ph == STX_PH_ADDR ##1 s_r.ph == STX_PH_ACC ##1
      s_r.ph == STX_PH_READ;
   endsequence

   a_trap_phase_order: assert property (
      s_r.ph == STX_IDLE && trap_req && is_trap && !repeat_active
      |=> s_three_phase ##1 s_r.ph == STX_VEC_REQ)
      else $error("Trap phases out of order");
   a_vec_addr_form: assert property (
      $rose(vec_rd) |-> vec_addr[7:0] == {s_r.idx, 3'b000})
      else $error("Vector address index wrong");
   a_mask_debug_kept: assert property (
      trap_busy && !soft_rst_req |=> $stable(st1[ST1_GIM_BIT])
      && $stable(st2[ST2_DEBUG_EVENT_DISABLE_BIT]))
      else $error("Trap altered mask or debug bit");
   a_addr_push: assert property (
      s_r.ph == STX_PH_ADDR |=> data_push.we && sys_push.we
      && data_push.addr == $past(s_r.sp) - 16'h0001
      && sys_push.data[8:0] == 9'h000)
      else $error("Address phase push wrong");
   a_acc_push: assert property (
      s_r.ph == STX_PH_ACC |=> sys_push.data == $past(s_r.debug_context_status)
      && sys_push.addr == $past(s_r.system_stack_pointer) - 16'h0001)
      else $error("Access phase push wrong");
   a_read_push_slow: assert property (
      s_r.ph == STX_PH_READ && !s_r.fast |=> data_push.we
      && data_push.data == $past(s_r.ret_pc[15:0]))
      else $error("Read phase push wrong");
   a_fast_pair: assert property (
      s_r.ph == STX_PH_READ && s_r.fast |=> !data_push.we
      && s_r.return_addr_reg == $past(s_r.ret_pc) && $stable(s_r.sp))
      else $error("Fast return pair not loaded");
   a_pc_load_clear: assert property (
      s_r.ph == STX_VEC_WAIT && vec_ack |=> pc_load
      && pc_value == $past(vec_data) && s_r.flow_ctx == 8'h00)
      else $error("Program counter load wrong");
   a_repeat_refused: assert property (
      s_r.ph == STX_IDLE && trap_req && repeat_active
      |=> trap_reject && !trap_busy)
      else $error("Repeated trap not refused");
   a_soft_reset_vals: assert property (
      soft_rst_req |=> st0 == ST0_RST && st2 == ST2_RST
      && st1[ST1_GIM_BIT] && irq_flags_clr && $stable(s_r.vector_ptr_dsp))
      else $error("Soft reset values wrong");

endmodule // stx_trap_unit
`default_nettype wire

//--- test/stx_stack_model.sv
`timescale 1ns/100ps
`default_nettype none
module stx_stack_model (
   input wire logic core_clk,
   input wire logic [3:0] dly,
   input wire stx_pkg::stx_push_s data_push,
   input wire stx_pkg::stx_push_s sys_push,
   input wire logic vec_rd,
   input wire logic [23:0] vec_addr,
   output logic vec_ack,
   output logic [23:0] vec_data
);
   import stx_pkg::*;
   // ***************************************************
   // Stack memories and vector read responder
   // ***************************************************
   logic [15:0] dstack [0:65535];
   logic [15:0] sstack [0:65535];
   logic [23:0] last_vaddr;
   logic [3:0] cnt;

   initial
   begin
      vec_ack = 1'b0;
      vec_data = 24'h000000;
      cnt = 4'h0;
      last_vaddr = 24'h000000;
   end

   always @(posedge core_clk)
   begin
      if (data_push.we)
         dstack[data_push.addr] <= data_push.data;
      if (sys_push.we)
         sstack[sys_push.addr] <= sys_push.data;
   end

   // Answer after dly cycles; data line toggles when idle
   always @(posedge core_clk)
   begin
      if (vec_rd && !vec_ack && cnt >= dly)
      begin
         vec_ack <= 1'b1;
         vec_data <= vec_addr ^ 24'h5a5a5a;
         last_vaddr <= vec_addr;
         cnt <= 4'h0;
      end
      else
      begin
         vec_ack <= 1'b0;
         vec_data <= ~vec_data;
         if (vec_rd && !vec_ack)
            cnt <= cnt + 4'h1;
      end
   end
endmodule // stx_stack_model
`default_nettype wire

//--- test/test_stx_trap_unit.sv
`timescale 1ns/100ps
`default_nettype none
module test_stx_trap_unit;
   import stx_pkg::*;
   logic core_clk, srst, wb_cyc, wb_stb, wb_we, wb_ack, trap_req;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel, mdl_dly;
   logic [31:0] wb_dat_w, wb_dat_r, q;
   logic [15:0] trap_opcode, st0, st1, st2;
   logic [23:0] trap_ret_pc, vec_addr, vec_data, pc_value, pc_seen;
   logic repeat_active, trap_busy, trap_reject, vec_rd, vec_ack, pc_load;
   logic soft_rst_req, irq_flags_clr, dbg_dis, emu_wr, rnd_sel;
   stx_push_s data_push, sys_push;
   int num_errors = 0, comparisons = 0, npush = 0, nrej = 0, npc = 0;
   int nclr = 0, n0;

   stx_trap_unit dut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
      .wb_ack_o(wb_ack), .trap_req(trap_req), .trap_opcode(trap_opcode),
      .trap_ret_pc(trap_ret_pc), .repeat_active(repeat_active),
      .trap_busy(trap_busy), .trap_reject(trap_reject), .vec_rd(vec_rd),
      .vec_addr(vec_addr), .vec_ack(vec_ack), .vec_data(vec_data),
      .pc_load(pc_load), .pc_value(pc_value), .soft_rst_req(soft_rst_req),
      .irq_flags_clr(irq_flags_clr), .data_push(data_push),
      .sys_push(sys_push), .st0(st0), .st1(st1), .st2(st2),
      .debug_event_disable(dbg_dis), .emulation_write_permit(emu_wr),
      .rounding_mode_select(rnd_sel));

   stx_stack_model mdl (.core_clk(core_clk), .dly(mdl_dly),
      .data_push(data_push), .sys_push(sys_push), .vec_rd(vec_rd),
      .vec_addr(vec_addr), .vec_ack(vec_ack), .vec_data(vec_data));

   // ***************************************************
   // Clock, monitors and shared tasks
   // ***************************************************
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   always @(negedge core_clk)
   begin
      npush = npush + int'(data_push.we === 1'b1) + int'(sys_push.we === 1'b1);
      nrej = nrej + int'(trap_reject === 1'b1);
      nclr = nclr + int'(irq_flags_clr === 1'b1);
      if (pc_load === 1'b1)
      begin
         npc++;
         pc_seen = pc_value;
      end
   end

   task final_report;
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task timeout;
      num_errors++;
      final_report;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int i;
      @(posedge core_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_sel <= 4'hf;
      wb_dat_w <= d;
      // Ack and read data sampled at the rising edge itself
      for (i = 0; i < 20; i++)
      begin
         @(posedge core_clk);
         if (wb_ack === 1'b1)
            break;
      end
      if (i == 20)
         timeout;
      q = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(q, exp);
   endtask

   task automatic trap(input logic [15:0] op, input logic [23:0] pc,
                       input logic rep);
      int i;
      int m;
      m = npc + nrej;
      @(posedge core_clk);
      trap_req <= 1'b1;
      trap_opcode <= op;
      trap_ret_pc <= pc;
      repeat_active <= rep;
      @(posedge core_clk);
      trap_req <= 1'b0;
      repeat_active <= 1'b0;
      for (i = 0; i < 100 && npc + nrej == m; i++)
         @(negedge core_clk);
      if (i == 100)
         timeout;
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial
   begin
      srst = 1'b1;
      {wb_cyc, wb_stb, wb_we, trap_req, repeat_active, soft_rst_req} = 6'h0;
      wb_adr = 8'h00;
      wb_sel = 4'hf;
      wb_dat_w = 32'h0;
      trap_opcode = 16'h0000;
      trap_ret_pc = 24'h000000;
      mdl_dly = 4'h0;
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      rd_chk(OFS_ST0, 32'h3800);
      rd_chk(OFS_ST2, 32'h1000);
      rd_chk(OFS_CTRL, 32'h0);
      rd_chk(8'h3c, 32'h0);
      wr(OFS_ST2, 32'hffff);
      rd_chk(OFS_ST2, 32'h9dff);
      check(32'({dbg_dis, emu_wr, rnd_sel}), 32'h7);
      $display("test reset values done");

      wr(OFS_ST0, 32'ha5ff);
      wr(OFS_ST2, 32'h0c05);
      wr(OFS_DSP, 32'h0100);
      wr(OFS_SSP, 32'h0200);
      wr(OFS_VECTOR_PTR_DSP, 32'h0012);
      wr(OFS_VECTOR_PTR_HOST, 32'h0034);
      wr(OFS_DBST, 32'h5a5a);
      wr(OFS_CTRL, 32'hc300);
      n0 = npush;
      trap(16'h9585, 24'h345678, 1'b0);
      check(32'(npush - n0), 32'd6);
      check(32'(mdl.dstack[16'h00ff]), 32'h0c05);
      check(32'(mdl.sstack[16'h01ff]), 32'ha400);
      check(32'(mdl.dstack[16'h00fe]), 32'h2920);
      check(32'(mdl.sstack[16'h01fe]), 32'h5a5a);
      check(32'(mdl.dstack[16'h00fd]), 32'h5678);
      check(32'(mdl.sstack[16'h01fd]), 32'hc334);
      // Index 5 selects the dsp pointer 0012
      check(32'(mdl.last_vaddr), 32'h001228);
      check(32'(pc_seen), 32'h5a4872);
      check(32'(trap_busy), 32'h0);
      rd_chk(OFS_STAT, 32'h0);
      rd_chk(OFS_DSP, 32'h00fd);
      rd_chk(OFS_SSP, 32'h01fd);
      rd_chk(OFS_ST2, 32'h0c05);
      rd_chk(OFS_ST1, 32'h2920);
      rd_chk(OFS_CTRL, 32'h0);
      $display("test slow trap done");

      wr(OFS_CTRL, 32'h5a01);
      mdl_dly <= 4'h5;
      n0 = npush;
      trap(16'h95f1, 24'habcdef, 1'b0);
      check(32'(npush - n0), 32'd4);
      rd_chk(OFS_RETPAIR, 32'h5aabcdef);
      rd_chk(OFS_DSP, 32'h00fb);
      rd_chk(OFS_SSP, 32'h01fb);
      check(32'(mdl.dstack[16'h00fb]), 32'h2920);
      // Index 11 is a host vector, pointer 0034
      check(32'(mdl.last_vaddr), 32'h003488);
      check(32'(pc_seen), 32'h5a6ed2);
      rd_chk(OFS_CTRL, 32'h0001);
      $display("test fast trap done");

      n0 = npush;
      trap(16'h9585, 24'h111111, 1'b1);
      trap(16'h9500, 24'h222222, 1'b0);
      check(32'(nrej), 32'd2);
      check(32'(npush - n0), 32'd0);
      rd_chk(OFS_STAT, 32'h4);
      $display("test refusal done");

      wr(OFS_ST0, 32'hffff);
      wr(OFS_ST1, 32'h0);
      wr(OFS_ST2, 32'hffff);
      @(posedge core_clk);
      soft_rst_req <= 1'b1;
      @(posedge core_clk);
      soft_rst_req <= 1'b0;
      @(negedge core_clk);
      check({st0, st2}, 32'h38001000);
      check(32'({dbg_dis, emu_wr}), 32'h2);
      check(32'(rnd_sel), 32'h0);
      check(32'(st2[8:0]), 32'h0);
      check(32'(st1[11]), 32'h1);
      repeat (2) @(negedge core_clk);
      check(32'(nclr), 32'd1);
      rd_chk(OFS_VECTOR_PTR_DSP, 32'h0012);
      rd_chk(OFS_ST0, 32'h3800);
      rd_chk(OFS_ST2, 32'h1000);
      $display("test soft reset done");
      final_report;
   end
endmodule // test_stx_trap_unit
`default_nettype wire
